// ### smi_pkg.sv
// constants, register map and helpers for the supply monitor and interrupt register block
package smi_pkg;

   // ==========================================================
   // bus and register map
   localparam int         ADDR_W        = 8;
   localparam logic [7:0] OFF_MON_CTRL  = 8'h00;
   localparam logic [7:0] OFF_EDGE_SEL  = 8'h04;
   localparam logic [7:0] OFF_IRQ_FIRST = 8'h08;
   localparam logic [7:0] OFF_IRQ_SEC   = 8'h0C;
   localparam logic [7:0] OFF_IRQ_THIRD = 8'h10;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // register selector codes
   localparam logic [2:0] SEL_MON   = 3'h0;
   localparam logic [2:0] SEL_EDGE  = 3'h1;
   localparam logic [2:0] SEL_FIRST = 3'h2;
   localparam logic [2:0] SEL_SEC   = 3'h3;
   localparam logic [2:0] SEL_THIRD = 3'h4;
   localparam logic [2:0] SEL_NONE  = 3'h7;

   // ==========================================================
   // monitor control fields, and the global enable bit of the first interrupt register
   localparam int MON_TRIP_LSB = 0;
   localparam int MON_REFBUF   = 3;
   localparam int MON_ON       = 4;
   localparam int MON_BELOW    = 5;
   localparam int GLOBAL_EN    = 0;

   // edge codes
   localparam logic [1:0] EDGE_OFF  = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // ==========================================================
   // interrupt sources, index 0 is the highest priority
   // 0 pin, 1 proximity, 2 converter, 3 period match, 4 compare match,
   // 5 supply monitor, 6 nvm, 7 time base 0, 8 time base 1, 9 serial
   localparam int NSRC    = 10;
   localparam int SRC_EXT = 0;
   localparam int SRC_MON = 5;
   localparam logic [NSRC-1:0][2:0] SRC_REG = {
      SEL_THIRD, SEL_THIRD, SEL_THIRD, SEL_SEC, SEL_SEC,
      SEL_SEC, SEL_SEC, SEL_FIRST, SEL_FIRST, SEL_FIRST};
   localparam logic [NSRC-1:0][2:0] SRC_FBIT = {
      3'h6, 3'h5, 3'h4, 3'h7, 3'h6, 3'h5, 3'h4, 3'h6, 3'h5, 3'h4};
   localparam logic [NSRC-1:0][2:0] SRC_EBIT = {
      3'h2, 3'h1, 3'h0, 3'h3, 3'h2, 3'h1, 3'h0, 3'h3, 3'h2, 3'h1};

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS  = 40;
   localparam int MON_DELAY_NS   = 15000;
   localparam int MON_DELAY_CYC  = (MON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   function automatic logic [2:0] smi_decode(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_MON_CTRL:  smi_decode = SEL_MON;
         OFF_EDGE_SEL:  smi_decode = SEL_EDGE;
         OFF_IRQ_FIRST: smi_decode = SEL_FIRST;
         OFF_IRQ_SEC:   smi_decode = SEL_SEC;
         OFF_IRQ_THIRD: smi_decode = SEL_THIRD;
         default:       smi_decode = SEL_NONE;
      endcase
   endfunction

   // trip level in millivolts
   function automatic logic [15:0] smi_trip_mv(input logic [2:0] c);
      case (c)
         3'h0:    smi_trip_mv = 16'h07D0;
         3'h1:    smi_trip_mv = 16'h0898;
         3'h2:    smi_trip_mv = 16'h0960;
         3'h3:    smi_trip_mv = 16'h0A8C;
         3'h4:    smi_trip_mv = 16'h0BB8;
         3'h5:    smi_trip_mv = 16'h0CE4;
         3'h6:    smi_trip_mv = 16'h0E10;
         default: smi_trip_mv = 16'h0FA0;
      endcase
   endfunction

endpackage

// ### smi_top.sv
// supply monitor flag logic and interrupt request/enable registers behind an AXI4-Lite slave
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module smi_top
   import smi_pkg::*;
#(
   parameter int MON_DELAY_CYCLES = MON_DELAY_CYC
) (
   // clock and reset
   input  wire logic              SYS_CLK,
   input  wire logic              RESETN,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic              AWVALID,
   output logic                   AWREADY,
   input  wire logic [31:0]       WDATA,
   input  wire logic [3:0]        WSTRB,
   input  wire logic              WVALID,
   output logic                   WREADY,
   output logic [1:0]             BRESP,
   output logic                   BVALID,
   input  wire logic              BREADY,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic              ARVALID,
   output logic                   ARREADY,
   output logic [31:0]            RDATA,
   output logic [1:0]             RRESP,
   output logic                   RVALID,
   input  wire logic              RREADY,
   // analog monitor side
   input  wire logic              LOW_SUPPLY_CMP,
   input  wire logic              RESET_LEVEL_ON,
   input  wire logic              DEEP_SLEEP,
   output logic                   DETECTOR_ON,
   output logic                   REF_ENABLE,
   output logic [2:0]             TRIP_LEVEL,
   output logic [15:0]            TRIP_LEVEL_MV,
   // interrupt sources
   input  wire logic              EXT_INT_PIN,
   input  wire logic [7:0]        SRC_EVENT,
   // core vectoring side
   input  wire logic              STACK_FULL,
   input  wire logic              IRQ_ACK,
   output logic                   IRQ_REQ,
   output logic [3:0]             IRQ_SRC,
   output logic                   WAKE
);

   // ==========================================================
   // state
   typedef struct packed {
      logic              aw_rdy;
      logic              w_rdy;
      logic              aw_have;
      logic              w_have;
      logic [ADDR_W-1:0] waddr;
      logic [7:0]        wdata;
      logic              wlane;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              ar_rdy;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic              cmp_s1;
      logic              cmp_s2;
      logic              pin_s1;
      logic              pin_s2;
      logic              pin_s3;
      logic [2:0]        trip;
      logic              ref_buf;
      logic              mon_on;
      logic              below;
      logic [15:0]       dly;
      logic              dly_done;
      logic [1:0]        edge_code;
      logic              global_irq_enable;
      logic [NSRC-1:0]   en;
      logic [NSRC-1:0]   fl;
      logic              irq_req;
      logic [3:0]        irq_src;
      logic              wake;
      logic              det_on;
      logic              ref_en;
      logic [15:0]       trip_mv;
   } smi_state_t;

   smi_state_t s_reg;
   smi_state_t s_next;

   // read view of one register; reserved bits stay zero
   function automatic logic [7:0] rd_byte(input smi_state_t s, input logic [2:0] sel);
      logic [7:0] b;
      b = 8'h00;
      case (sel)
         SEL_MON: begin
            b[MON_TRIP_LSB +: 3] = s.trip;
            b[MON_REFBUF]        = s.ref_buf;
            b[MON_ON]            = s.mon_on;
            b[MON_BELOW]         = s.below;
         end
         SEL_EDGE: begin
            b[1:0] = s.edge_code;
         end
         default: begin
         end
      endcase
      if (sel == SEL_FIRST) begin
         b[GLOBAL_EN] = s.global_irq_enable;
      end
      for (int i = 0; i < NSRC; i++) begin
         if (SRC_REG[i] == sel) begin
            b[SRC_FBIT[i]] = s.fl[i];
            b[SRC_EBIT[i]] = s.en[i];
         end
      end
      return b;
   endfunction

   // ==========================================================
   // next state
   logic            det_active;
   logic            mon_set;
   logic            pin_rise;
   logic            pin_fall;
   logic [NSRC-1:0] set_v;
   logic [NSRC-1:0] clr_v;
   logic [NSRC-1:0] pend;
   logic            do_wr;
   logic            wr_ok;
   logic [2:0]      wsel;
   logic            ack;
   logic [3:0]      win;

   always_comb begin
      s_next = s_reg;
      mon_set = 1'b0;
      clr_v = '0;
      win = 4'h0;

      // synchronisers for pins from outside the clock domain
      s_next.cmp_s1 = LOW_SUPPLY_CMP;
      s_next.cmp_s2 = s_reg.cmp_s1;
      s_next.pin_s1 = EXT_INT_PIN;
      s_next.pin_s2 = s_reg.pin_s1;
      s_next.pin_s3 = s_reg.pin_s2;

      // monitor
      det_active = s_reg.mon_on & ~DEEP_SLEEP;
      s_next.det_on = det_active;
      s_next.ref_en = s_reg.mon_on | RESET_LEVEL_ON | s_reg.ref_buf;
      s_next.below = det_active & s_reg.cmp_s2;
      s_next.trip_mv = smi_trip_mv(s_reg.trip);
      // one request per low episode, after below has stayed set for MON_DELAY_CYCLES cycles; any drop of below rearms it
      if (!s_reg.below) begin
         s_next.dly = 16'h0000;
         s_next.dly_done = 1'b0;
      end else if (!s_reg.dly_done) begin
         if (s_reg.dly == 16'(MON_DELAY_CYCLES - 1)) begin
            s_next.dly_done = 1'b1;
            mon_set = 1'b1;
         end else begin
            s_next.dly = s_reg.dly + 16'h0001;
         end
      end

      // pin edge detection on synchronised samples
      pin_rise = s_reg.pin_s2 & ~s_reg.pin_s3;
      pin_fall = ~s_reg.pin_s2 & s_reg.pin_s3;
      set_v = {SRC_EVENT[7:4], mon_set, SRC_EVENT[3:0],
               (s_reg.edge_code[0] & pin_rise) | (s_reg.edge_code[1] & pin_fall)};

      // core acknowledge
      ack = IRQ_ACK & s_reg.irq_req;
      if (ack) begin
         clr_v[s_reg.irq_src] = 1'b1;
      end

      // axi write channels, taken in either order
      if (AWVALID && s_reg.aw_rdy) begin
         s_next.aw_have = 1'b1;
         s_next.aw_rdy = 1'b0;
         s_next.waddr = AWADDR;
      end
      if (WVALID && s_reg.w_rdy) begin
         s_next.w_have = 1'b1;
         s_next.w_rdy = 1'b0;
         s_next.wdata = WDATA[7:0];
         s_next.wlane = WSTRB[0];
      end
      do_wr = s_reg.aw_have & s_reg.w_have & ~s_reg.bvalid;
      wsel = smi_decode(s_reg.waddr);
      wr_ok = do_wr & (wsel != SEL_NONE) & s_reg.wlane;
      if (do_wr) begin
         s_next.aw_have = 1'b0;
         s_next.w_have = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_reg.bvalid && BREADY) begin
         s_next.bvalid = 1'b0;
         s_next.aw_rdy = 1'b1;
         s_next.w_rdy = 1'b1;
      end

      if (wr_ok && wsel == SEL_MON) begin
         s_next.trip = s_reg.wdata[MON_TRIP_LSB +: 3];
         s_next.ref_buf = s_reg.wdata[MON_REFBUF];
         s_next.mon_on = s_reg.wdata[MON_ON];
      end
      if (wr_ok && wsel == SEL_EDGE) begin
         s_next.edge_code = s_reg.wdata[1:0];
      end
      if (wr_ok && wsel == SEL_FIRST) begin
         s_next.global_irq_enable = s_reg.wdata[GLOBAL_EN];
      end
      if (ack) begin
         s_next.global_irq_enable = 1'b0;
      end

      // flags: hardware set beats software clear and acknowledge
      for (int i = 0; i < NSRC; i++) begin
         if (wr_ok && wsel == SRC_REG[i]) begin
            s_next.en[i] = s_reg.wdata[SRC_EBIT[i]];
            s_next.fl[i] = s_reg.wdata[SRC_FBIT[i]];
         end
         s_next.fl[i] = (s_next.fl[i] & ~clr_v[i]) | set_v[i];
      end

      // fixed priority, lowest index wins
      pend = s_reg.fl & s_reg.en;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            win = 4'(i);
         end
      end
      s_next.irq_req = s_reg.global_irq_enable & (|pend) & ~STACK_FULL & ~ack;
      s_next.irq_src = win;
      s_next.wake = |s_reg.fl;

      // axi read
      if (ARVALID && s_reg.ar_rdy) begin
         s_next.ar_rdy = 1'b0;
         s_next.rvalid = 1'b1;
         s_next.rdata = {24'h000000, rd_byte(s_reg, smi_decode(ARADDR))};
         s_next.rresp = (smi_decode(ARADDR) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_reg.rvalid && RREADY) begin
         s_next.rvalid = 1'b0;
         s_next.ar_rdy = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_reg <= '0;
         s_reg.aw_rdy <= 1'b1;
         s_reg.w_rdy <= 1'b1;
         s_reg.ar_rdy <= 1'b1;
         s_reg.trip_mv <= 16'h07D0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs
   assign AWREADY       = s_reg.aw_rdy;
   assign WREADY        = s_reg.w_rdy;
   assign BVALID        = s_reg.bvalid;
   assign BRESP         = s_reg.bresp;
   assign ARREADY       = s_reg.ar_rdy;
   assign RVALID        = s_reg.rvalid;
   assign RDATA         = s_reg.rdata;
   assign RRESP         = s_reg.rresp;
   assign DETECTOR_ON   = s_reg.det_on;
   assign REF_ENABLE    = s_reg.ref_en;
   assign TRIP_LEVEL    = s_reg.trip;
   assign TRIP_LEVEL_MV = s_reg.trip_mv;
   assign IRQ_REQ       = s_reg.irq_req;
   assign IRQ_SRC       = s_reg.irq_src;
   assign WAKE          = s_reg.wake;

   // ==========================================================
   // assertions
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESETN);

   property p_glob;
      IRQ_REQ |-> $past(s_reg.global_irq_enable);
   endproperty
   a_glob: assert property (p_glob) else $error("request without global enable");

   property p_stack;
      IRQ_REQ |-> !$past(STACK_FULL);
   endproperty
   a_stack: assert property (p_stack) else $error("request while stack full");

   property p_ack_clr;
      (IRQ_ACK && IRQ_REQ) |=> !s_reg.global_irq_enable ##1 !IRQ_REQ;
   endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("global enable not cleared");

   property p_enabled;
      IRQ_REQ |-> ($past(s_reg.fl) & $past(s_reg.en)) >> IRQ_SRC == 10'h001 ||
                  ((($past(s_reg.fl) & $past(s_reg.en)) >> IRQ_SRC) & 10'h001) == 10'h001;
   endproperty
   a_enabled: assert property (p_enabled) else $error("presented source not pending");

   property p_prio;
      IRQ_REQ |-> (($past(s_reg.fl) & $past(s_reg.en)) & ((10'h001 << IRQ_SRC) - 10'h001))
                  == 10'h000;
   endproperty
   a_prio: assert property (p_prio) else $error("lower priority source presented");

   property p_sleep;
      DEEP_SLEEP |=> !DETECTOR_ON && !s_reg.below;
   endproperty
   a_sleep: assert property (p_sleep) else $error("detector on in deep sleep");

   property p_ref;
      (s_reg.mon_on || RESET_LEVEL_ON || s_reg.ref_buf) |=> REF_ENABLE;
   endproperty
   a_ref: assert property (p_ref) else $error("reference not enabled");

   property p_mon_rd;
      (ARVALID && ARREADY && ARADDR == OFF_MON_CTRL) |=> RVALID && RDATA[7:6] == 2'h0;
   endproperty
   a_mon_rd: assert property (p_mon_rd) else $error("monitor reserved bits nonzero");

   property p_edge_rd;
      (ARVALID && ARREADY && ARADDR == OFF_EDGE_SEL) |=> RVALID && RDATA[7:2] == 6'h00;
   endproperty
   a_edge_rd: assert property (p_edge_rd) else $error("edge reserved bits nonzero");

   property p_delay;
      (s_reg.below && !s_reg.dly_done && s_reg.dly == 16'(MON_DELAY_CYCLES - 1))
         |=> s_reg.fl[SRC_MON] && s_reg.dly_done;
   endproperty
   a_delay: assert property (p_delay) else $error("monitor flag not set after delay");

   property p_pin;
      (s_reg.edge_code == EDGE_RISE && s_reg.pin_s2 && !s_reg.pin_s3) |=> s_reg.fl[SRC_EXT];
   endproperty
   a_pin: assert property (p_pin) else $error("rising edge did not set pin flag");

   property p_wake;
      (|s_reg.fl) |=> WAKE;
   endproperty
   a_wake: assert property (p_wake) else $error("set flag did not wake");

   c_ack:  cover property (IRQ_REQ && IRQ_ACK);
   c_mon:  cover property (mon_set);
   c_both: cover property (s_reg.edge_code == EDGE_BOTH && pin_fall);
   c_wr:   cover property (BVALID && BREADY && BRESP == RESP_OKAY);

endmodule

// ### smi_core_model.sv
// behavioural model of the core vectoring side that takes presented interrupts
`timescale 1ns/1ps
module smi_core_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // from the block
   input  wire logic       irq_req,
   input  wire logic [3:0] irq_src,
   // bench control
   input  wire logic       ack_en,
   input  wire logic [3:0] delay,
   // to the block and the bench
   output logic            irq_ack,
   output logic [3:0]      last_src,
   output logic [7:0]      ack_cnt
);
   logic [3:0] wait_cnt;

   // ==========================================================
   // acknowledge after a chosen number of cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ack  <= 1'b0;
         wait_cnt <= 4'h0;
         last_src <= 4'h0;
         ack_cnt  <= 8'h00;
      end else if (irq_ack) begin
         // single pulse, then wait for a fresh presentation
         irq_ack  <= 1'b0;
         wait_cnt <= 4'h0;
         if (irq_req) begin
            last_src <= irq_src;
            ack_cnt  <= ack_cnt + 8'h01;
         end
      end else if (irq_req && ack_en) begin
         if (wait_cnt >= delay) begin
            irq_ack <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end else begin
         wait_cnt <= 4'h0;
      end
   end
endmodule

// ### supply_monitor_and_interrupt_regs_bench.sv
// self-checking bench for the supply monitor and interrupt register block
`timescale 1ns/1ps
module supply_monitor_and_interrupt_regs_bench;
   import smi_pkg::*;
   // ==========================================================
   // signals
   logic        SYS_CLK = 0, RESETN = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
   logic        ARVALID = 0, RREADY = 0, LOW_SUPPLY_CMP = 0, RESET_LEVEL_ON = 0;
   logic        DEEP_SLEEP = 0, EXT_INT_PIN = 0, STACK_FULL = 0, ack_en = 0;
   logic [7:0]  AWADDR = 0, ARADDR = 0, SRC_EVENT = 0, ack_cnt;
   logic [31:0] WDATA = 0, RDATA;
   logic [3:0]  WSTRB = 0, dly = 0, IRQ_SRC, last_src;
   logic [1:0]  BRESP, RRESP;
   logic [2:0]  TRIP_LEVEL;
   logic [15:0] TRIP_LEVEL_MV;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, DETECTOR_ON, REF_ENABLE;
   logic        IRQ_ACK, IRQ_REQ, WAKE;
   logic [3:0]  lane_mask = 4'hF;
   int          mismatches = 0, samples_checked = 0;

   always #20 SYS_CLK = ~SYS_CLK;

   smi_top #(.MON_DELAY_CYCLES(4)) uut (
      .SYS_CLK(SYS_CLK), .RESETN(RESETN), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
      .RVALID(RVALID), .RREADY(RREADY), .LOW_SUPPLY_CMP(LOW_SUPPLY_CMP),
      .RESET_LEVEL_ON(RESET_LEVEL_ON), .DEEP_SLEEP(DEEP_SLEEP),
      .DETECTOR_ON(DETECTOR_ON), .REF_ENABLE(REF_ENABLE), .TRIP_LEVEL(TRIP_LEVEL),
      .TRIP_LEVEL_MV(TRIP_LEVEL_MV), .EXT_INT_PIN(EXT_INT_PIN), .SRC_EVENT(SRC_EVENT),
      .STACK_FULL(STACK_FULL), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_SRC(IRQ_SRC),
      .WAKE(WAKE));

   smi_core_model core (
      .clk(SYS_CLK), .rst_n(RESETN), .irq_req(IRQ_REQ), .irq_src(IRQ_SRC),
      .ack_en(ack_en), .delay(dly), .irq_ack(IRQ_ACK), .last_src(last_src),
      .ack_cnt(ack_cnt));

   // ==========================================================
   // checking and reporting
   task automatic check_data(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic timeout();
      mismatches++;
      $display("MISMATCH handshake expected answer seen none");
      print_verdict();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge SYS_CLK);
   endtask

   function automatic logic [15:0] trip_mv(input int c);
      logic [15:0] t [8] = '{16'h07D0, 16'h0898, 16'h0960, 16'h0A8C,
                             16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0};
      return t[c];
   endfunction

   // ==========================================================
   // axi4-lite master
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] rs);
      bit aw, w, done;
      aw = 0;
      w = 0;
      done = 0;
      @(posedge SYS_CLK);
      AWADDR <= a;
      WDATA <= {24'h000000, d};
      WSTRB <= lane_mask;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      for (int n = 0; n < 60 && !done; n++) begin
         @(posedge SYS_CLK);
         if (aw && w && BVALID === 1'b1) begin
            rs = BRESP;
            BREADY <= 1'b0;
            done = 1;
         end
         if (AWVALID && AWREADY === 1'b1) begin
            aw = 1;
            AWVALID <= 1'b0;
         end
         if (WVALID && WREADY === 1'b1) begin
            w = 1;
            WVALID <= 1'b0;
         end
      end
      if (!done) timeout();
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      bit done;
      done = 0;
      @(posedge SYS_CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      for (int n = 0; n < 60 && !done; n++) begin
         @(posedge SYS_CLK);
         if (!ARVALID && RVALID === 1'b1) begin
            d = RDATA;
            rs = RRESP;
            RREADY <= 1'b0;
            done = 1;
         end
         if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
      end
      if (!done) timeout();
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] rs;
      axi_wr(a, d, rs);
      check_resp("bresp", RESP_OKAY, rs);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  rs;
      axi_rd(a, d, rs);
      check_resp("rresp", RESP_OKAY, rs);
      check_data($sformatf("register %h", a), {24'h000000, e}, d);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  x;
      x = 8'($urandom(51));
      cyc(20);
      RESETN <= 1'b1;
      @(posedge SYS_CLK);
      rd(OFF_MON_CTRL, 8'h00);
      rd(OFF_EDGE_SEL, 8'h00);
      rd(OFF_IRQ_FIRST, 8'h00);
      rd(OFF_IRQ_SEC, 8'h00);
      rd(OFF_IRQ_THIRD, 8'h00);
      check_data("trip mv", 32'(trip_mv(0)), 32'(TRIP_LEVEL_MV));
      axi_wr(8'h14, 8'hFF, r);
      check_resp("bresp unmapped", RESP_SLVERR, r);
      axi_rd(8'h14, d, r);
      check_resp("rresp unmapped", RESP_SLVERR, r);
      check_data("rdata unmapped", 32'h00000000, d);
      // low byte lane off: accepted, but the register keeps its value
      lane_mask = 4'hE;
      wr(OFF_EDGE_SEL, 8'h03);
      lane_mask = 4'hF;
      rd(OFF_EDGE_SEL, 8'h00);
      // register masks, global enable kept off so nothing is vectored
      for (int i = 0; i < 6; i++) begin
         x = (i == 0) ? 8'hFF : 8'($urandom);
         wr(OFF_EDGE_SEL, x);
         rd(OFF_EDGE_SEL, x & 8'h03);
         wr(OFF_IRQ_FIRST, x & 8'hFE);
         rd(OFF_IRQ_FIRST, x & 8'h7E);
         wr(OFF_IRQ_SEC, x);
         rd(OFF_IRQ_SEC, x);
         wr(OFF_IRQ_THIRD, x);
         rd(OFF_IRQ_THIRD, x & 8'h77);
         wr(OFF_MON_CTRL, x);
         rd(OFF_MON_CTRL, x & 8'h1F);
      end
      for (int i = 0; i < 8; i++) begin
         wr(OFF_MON_CTRL, 8'h10 | 8'(i));
         cyc(3);
         check_data("trip code", 32'(i), 32'(TRIP_LEVEL));
         check_data("trip mv", 32'(trip_mv(i)), 32'(TRIP_LEVEL_MV));
      end
      for (int i = 0; i < 16; i++) begin
         @(posedge SYS_CLK);
         RESET_LEVEL_ON <= i[2];
         DEEP_SLEEP <= i[3];
         wr(OFF_MON_CTRL, {3'h0, i[0], i[1], 3'h0});
         cyc(3);
         check_data("detector", 32'(i[0] & ~i[3]), 32'(DETECTOR_ON));
         check_data("reference", 32'(i[0] | i[1] | i[2]), 32'(REF_ENABLE));
      end
      // low supply episode with the monitor request enabled
      @(posedge SYS_CLK);
      DEEP_SLEEP <= 1'b0;
      RESET_LEVEL_ON <= 1'b0;
      wr(OFF_IRQ_FIRST, 8'h00);
      wr(OFF_IRQ_SEC, 8'h04);
      wr(OFF_IRQ_THIRD, 8'h00);
      wr(OFF_MON_CTRL, 8'h13);
      @(posedge SYS_CLK);
      LOW_SUPPLY_CMP <= 1'b1;
      cyc(2);
      rd(OFF_IRQ_SEC, 8'h04);
      rd(OFF_MON_CTRL, 8'h33);
      cyc(10);
      rd(OFF_IRQ_SEC, 8'h44);
      check_data("wake", 32'h1, 32'(WAKE));
      @(posedge SYS_CLK);
      DEEP_SLEEP <= 1'b1;
      cyc(4);
      rd(OFF_MON_CTRL, 8'h13);
      @(posedge SYS_CLK);
      LOW_SUPPLY_CMP <= 1'b0;
      DEEP_SLEEP <= 1'b0;
      wr(OFF_IRQ_SEC, 8'h00);
      wr(OFF_MON_CTRL, 8'h00);
      cyc(4);
      check_data("wake", 32'h0, 32'(WAKE));
      // every edge code against a rising and a falling pin edge
      for (int i = 0; i < 4; i++) begin
         wr(OFF_EDGE_SEL, 8'(i));
         @(posedge SYS_CLK);
         EXT_INT_PIN <= 1'b1;
         cyc(6);
         rd(OFF_IRQ_FIRST, i[0] ? 8'h10 : 8'h00);
         wr(OFF_IRQ_FIRST, 8'h00);
         @(posedge SYS_CLK);
         EXT_INT_PIN <= 1'b0;
         cyc(6);
         rd(OFF_IRQ_FIRST, i[1] ? 8'h10 : 8'h00);
         wr(OFF_IRQ_FIRST, 8'h00);
      end
      // every source but the supply monitor at once, masked, then stack full, then by priority
      wr(OFF_EDGE_SEL, {6'h00, EDGE_RISE});
      wr(OFF_IRQ_FIRST, 8'h0E);
      wr(OFF_IRQ_SEC, 8'h0F);
      wr(OFF_IRQ_THIRD, 8'h07);
      @(posedge SYS_CLK);
      SRC_EVENT <= 8'hFF;
      EXT_INT_PIN <= 1'b1;
      @(posedge SYS_CLK);
      SRC_EVENT <= 8'h00;
      cyc(8);
      check_data("irq req", 32'h0, 32'(IRQ_REQ));
      rd(OFF_IRQ_FIRST, 8'h7E);
      rd(OFF_IRQ_SEC, 8'hBF);
      rd(OFF_IRQ_THIRD, 8'h77);
      @(posedge SYS_CLK);
      STACK_FULL <= 1'b1;
      ack_en <= 1'b1;
      wr(OFF_IRQ_FIRST, 8'h7F);
      cyc(6);
      check_data("irq req", 32'h0, 32'(IRQ_REQ));
      @(posedge SYS_CLK);
      STACK_FULL <= 1'b0;
      for (int k = 0; k < 9; k++) begin
         x = ack_cnt;
         for (int i = 0; i < 60 && ack_cnt == x; i++) @(posedge SYS_CLK);
         if (ack_cnt == x) timeout();
         check_data("source", (k < 5) ? 32'(k) : 32'(k + 1), 32'(last_src));
         cyc(2);
         check_data("irq req", 32'h0, 32'(IRQ_REQ));
         dly <= 4'($urandom_range(5));
         axi_rd(OFF_IRQ_FIRST, d, r);
         wr(OFF_IRQ_FIRST, d[7:0] | 8'h01);
      end
      // proximity enable off: its flag must record without a request
      wr(OFF_IRQ_FIRST, 8'h0B);
      @(posedge SYS_CLK);
      SRC_EVENT <= 8'h01;
      @(posedge SYS_CLK);
      SRC_EVENT <= 8'h00;
      cyc(4);
      check_data("irq req", 32'h0, 32'(IRQ_REQ));
      rd(OFF_IRQ_FIRST, 8'h2B);
      print_verdict();
   end
endmodule
